// ### hdl/swdsp_line_engine.sv
/*
 * Bit-level engine of the debug wire: edge detect, receive, transmit, ack pulse.
 * Assumes the pin is open drain with a pull-up and a host that starts each bit.
 */
`timescale 1ns/1ps
module swdsp_line_engine (
    input wire logic clk_sys, // System clock
    input wire logic reset_n, // Asynchronous reset
    input wire logic pin_in, // Pin level
    output logic pin_out, // Pin drive value
    output logic pin_oe, // Pin drive enable
    input wire logic listen, // Accept host bit edges
    input wire logic tx_mode, // Current bit returns data
    input wire logic tx_bit, // Bit to return
    input wire logic ack_start, // Start completion pulse
    output swdsp_pkg::swdsp_line_ev_t ev // Line events
);
    typedef enum logic [1:0] {E_IDLE, E_BIT, E_ACK} swdsp_eng_t;
    swdsp_eng_t st_ff;
    logic [1:0] sync_ff;
    logic prev_ff;
    logic hi8_ff;
    logic val_ff;
    logic txm_ff;
    logic [9:0] cnt_ff;
    logic [9:0] gap_ff;
    logic [7:0] low_ff;
    wire logic pin_s = sync_ff[1];
    wire logic fall = prev_ff & ~pin_s;
    wire logic in_bit = (st_ff == E_BIT);
    wire logic in_ack = (st_ff == E_ACK);
    wire logic at_end = (cnt_ff == 10'(swdsp_pkg::BIT_TICKS - 1));
    wire logic ack_end = (cnt_ff == 10'(swdsp_pkg::ACK_LOW));
    wire logic at_smp = (cnt_ff == 10'(swdsp_pkg::RX_SAMPLE));
    wire logic at_chk = (cnt_ff == 10'(swdsp_pkg::GLITCH_CHK));
    wire logic gap_max = (gap_ff == 10'(swdsp_pkg::TIMEOUT_TICKS));
    wire logic low_max = (low_ff == 8'(swdsp_pkg::SYNC_LOW));
    wire logic drv1 = in_bit & txm_ff & tx_bit & (cnt_ff == 10'(swdsp_pkg::TX1_SPEEDUP));
    wire logic drv0 = in_bit & txm_ff & ~tx_bit & (cnt_ff < 10'(swdsp_pkg::TX0_LOW));
    wire logic drv0p = in_bit & txm_ff & ~tx_bit & (cnt_ff == 10'(swdsp_pkg::TX0_LOW));
    wire logic ackl = in_ack & (cnt_ff < 10'(swdsp_pkg::ACK_LOW));

    // Pin drive
    assign pin_oe = drv1 | drv0 | drv0p | ackl | (in_ack & ack_end);
    assign pin_out = drv1 | drv0p | (in_ack & ack_end);

    // Event outputs
    assign ev.fall = fall;
    assign ev.bit_done = in_bit & at_end;
    assign ev.bit_val = val_ff;
    assign ev.timeout = (gap_ff == 10'(swdsp_pkg::TIMEOUT_TICKS - 1));
    assign ev.long_low = ~pin_s & (low_ff == 8'(swdsp_pkg::SYNC_LOW - 1));
    assign ev.ack_done = in_ack & ack_end;

    // Two-stage synchroniser, then edge history
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync_ff <= 2'h3;
            prev_ff <= 1'b1;
        end else begin
            sync_ff <= {sync_ff[0], pin_in};
            prev_ff <= pin_s;
        end
    end

    // Gap and low-time counters, both saturating
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gap_ff <= 10'h000;
            low_ff <= 8'h00;
        end else begin
            gap_ff <= fall ? 10'h000 : (gap_max ? gap_ff : gap_ff + 10'h001);
            low_ff <= pin_s ? 8'h00 : (low_max ? low_ff : low_ff + 8'h01);
        end
    end

    // Bit and ack sequencer
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= E_IDLE;
            cnt_ff <= 10'h000;
            hi8_ff <= 1'b0;
            val_ff <= 1'b0;
            txm_ff <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 10'h001;
            if (in_bit && at_chk) hi8_ff <= pin_s;
            if (in_bit && at_smp) val_ff <= pin_s & hi8_ff;
            unique case (st_ff)
                E_IDLE: begin
                    cnt_ff <= 10'h000;
                    if (ack_start) begin
                        st_ff <= E_ACK;
                    end else if (fall && listen) begin
                        st_ff <= E_BIT;
                        txm_ff <= tx_mode;
                    end
                end
                E_BIT: if (at_end) st_ff <= E_IDLE;
                E_ACK: if (ack_end) st_ff <= E_IDLE;
            endcase
        end
    end
endmodule : swdsp_line_engine

// ### hdl/swdsp_pkg.sv
/*
 * Constants, opcodes and carrier types of the single-wire debug serial port.
 * Assumes one clock that serves as both target serial clock and bus clock.
 */
// Operation
// - 8-bit opcode, then address and/or data
// - Reads return 16 bits
// - Byte read: even upper, odd lower
// - Word access drops address bit zero
// - Steal a bus cycle within 128
// - Host edge starts bits; MSB first, 16 cycles
// - 512 idle cycles abandon transfer
// - Open drain; transmitter drives speedup
// - Sample ten cycles after edge
// - Returned one: speedup at cycle seven
// - Returned zero: low 13, then speedup
// - Completion pulse: 16 low, then speedup
// - Pulse at least 32 cycles after command
// - Pulse when read ready or write done
// - No pulse while stopped or ignored
// - D5 enables handshake with pulse, D6 disables
// - Long low aborts pending handshake
// - Never two pending pulses
// - Next-pointer reaches debug space, firmware read-only
package swdsp_pkg;
    // Bit timing in target clock cycles
    localparam int BIT_TICKS = 16;
    localparam int RX_SAMPLE = 10;
    localparam int GLITCH_CHK = 8;
    localparam int TX1_SPEEDUP = 7;
    localparam int TX0_LOW = 13;
    localparam int TIMEOUT_TICKS = 512;
    localparam int ACK_LOW = 16;
    localparam int ACK_GAP = 32;
    localparam int SYNC_LOW = 128;
    localparam int STEAL_WAIT = 128;
    localparam int OPC_BITS = 8;
    localparam int WORD_BITS = 16;
    // Opcodes
    localparam logic [7:0] OP_BACKGROUND = 8'h90;
    localparam logic [7:0] OP_ACK_ON = 8'hd5;
    localparam logic [7:0] OP_ACK_OFF = 8'hd6;
    localparam logic [7:0] OP_RD_NEXT = 8'h62;
    localparam logic [7:0] OP_WR_NEXT = 8'h42;
    localparam logic [7:0] OP_GO = 8'h08;
    localparam logic [7:0] OP_GO_UNTIL = 8'h0c;
    localparam logic [7:0] OP_SINGLE_STEP_CMD = 8'h10;
    localparam logic [7:0] OP_TAGGO = 8'h18;
    // Hardware memory opcode fields
    localparam logic [1:0] HW_MEM_TOP = 2'b11;
    localparam int OPB_READ = 5;
    localparam int OPB_SEL = 4;
    localparam int OPB_WORD = 3;
    localparam int OPB_DBG = 2;
    // Firmware register opcode fields
    localparam logic [3:0] FW_RD_HI = 4'h6;
    localparam logic [3:0] FW_WR_HI = 4'h4;
    localparam logic [3:0] FW_REG_LO = 4'h2;
    localparam logic [3:0] FW_REG_HI = 4'h7;
    // Debug window and its protected firmware part
    localparam logic [15:0] DBG_WIN_LO = 16'hff00;
    localparam logic [15:0] DBG_FW_HI = 16'hff7f;
    localparam logic [15:0] PTR_STEP = 16'h0002;
    localparam logic [1:0] BE_WORD = 2'b11;
    localparam logic [1:0] BE_EVEN = 2'b10;
    localparam logic [1:0] BE_ODD = 2'b01;

    // Memory access toward the bus
    typedef struct packed {
        logic we;
        logic dbg;
        logic [1:0] be;
        logic [15:0] addr;
        logic [15:0] wdata;
    } swdsp_mem_req_t;

    // Firmware command toward the core
    typedef struct packed {
        logic [7:0] opcode;
        logic [15:0] data;
    } swdsp_core_req_t;

    // Line events from the bit engine
    typedef struct packed {
        logic fall;
        logic bit_done;
        logic bit_val;
        logic timeout;
        logic long_low;
        logic ack_done;
    } swdsp_line_ev_t;
endpackage : swdsp_pkg

// ### hdl/swdsp_top.sv
/*
 * Device end of the single-wire debug serial port: command decode, bus and
 * core requests, read-back shifting and the completion handshake.
 * Assumes a bus arbiter honouring mem_steal and a core running firmware commands.
 */
`timescale 1ns/1ps
module swdsp_top (
    input wire logic clk_sys, // System and target clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic debug_wire_pin_in, // Debug pin level
    output logic debug_wire_pin_out, // Debug pin drive value
    output logic debug_wire_pin_oe, // Debug pin drive enable
    input wire logic stop_mode, // System is stopped
    input wire logic bdm_active, // Core is in active background mode
    input wire logic bus_free, // Bus has a free cycle
    output logic mem_valid, // Bus access request
    output logic mem_steal, // Access takes a stolen cycle
    output swdsp_pkg::swdsp_mem_req_t mem_cmd, // Bus access fields
    input wire logic mem_done, // Bus access finished
    input wire logic [15:0] mem_rdata, // Bus read word
    output logic core_valid, // Firmware command request
    output swdsp_pkg::swdsp_core_req_t core_cmd, // Firmware command fields
    input wire logic core_done, // Firmware command finished
    input wire logic [15:0] core_rdata, // Firmware read word
    input wire logic [15:0] core_ptr, // Core index pointer
    output logic ptr_bump, // Advance the core index pointer
    output logic ack_enabled // Handshake enabled
);
    typedef enum logic [2:0] {S_OPC, S_ADDR, S_DATA, S_EXEC, S_ACK, S_TX} swdsp_st_t;
    swdsp_st_t st_ff;
    swdsp_pkg::swdsp_line_ev_t ev;
    logic [7:0] op_ff;
    logic [15:0] addr_ff;
    logic [15:0] sh_ff;
    logic [3:0] bit_ff;
    logic [5:0] agap_ff;
    logic [7:0] wait_ff;
    logic issued_ff;
    logic ack_en_ff;
    logic ackgo_ff;
    logic got_addr_ff;
    logic got_data_ff;

    // Opcode classes
    wire logic [3:0] op_hi = op_ff[7:4];
    wire logic [3:0] op_lo = op_ff[3:0];
    wire logic is_mem = (op_ff[7:6] == swdsp_pkg::HW_MEM_TOP) & ~op_ff[swdsp_pkg::OPB_SEL]
        & (op_ff[1:0] == 2'b00);
    wire logic mem_rd = is_mem & op_ff[swdsp_pkg::OPB_READ];
    wire logic mem_wd = op_ff[swdsp_pkg::OPB_WORD];
    wire logic fw_reg = (op_lo >= swdsp_pkg::FW_REG_LO) & (op_lo <= swdsp_pkg::FW_REG_HI);
    wire logic fw_rd = (op_hi == swdsp_pkg::FW_RD_HI) & fw_reg;
    wire logic fw_wr = (op_hi == swdsp_pkg::FW_WR_HI) & fw_reg;
    wire logic is_next = (op_ff == swdsp_pkg::OP_RD_NEXT) | (op_ff == swdsp_pkg::OP_WR_NEXT);
    wire logic fw_ctl = (op_ff == swdsp_pkg::OP_GO) | (op_ff == swdsp_pkg::OP_GO_UNTIL)
        | (op_ff == swdsp_pkg::OP_SINGLE_STEP_CMD) | (op_ff == swdsp_pkg::OP_TAGGO);
    wire logic is_bg = (op_ff == swdsp_pkg::OP_BACKGROUND);
    wire logic is_ackon = (op_ff == swdsp_pkg::OP_ACK_ON);
    wire logic is_ackoff = (op_ff == swdsp_pkg::OP_ACK_OFF);
    wire logic is_read = mem_rd | fw_rd;
    wire logic fw_any = fw_rd | fw_wr | fw_ctl;
    // No access before its address and data fields are in
    wire logic ready_go = (~is_mem | (got_addr_ff & (mem_rd | got_data_ff)))
        & (~fw_wr | got_data_ff);

    // Next-pointer target and its window checks
    wire logic [15:0] nxt_ptr = core_ptr + swdsp_pkg::PTR_STEP;
    wire logic nxt_dbg = (nxt_ptr >= swdsp_pkg::DBG_WIN_LO);
    wire logic nxt_prot = nxt_dbg & (nxt_ptr <= swdsp_pkg::DBG_FW_HI);
    wire logic nxt_rej = is_next & fw_wr & nxt_prot;

    // Byte placement for hardware reads of one byte
    wire logic [15:0] rd_even = {mem_rdata[15:8], 8'h00};
    wire logic [15:0] rd_odd = {8'h00, mem_rdata[7:0]};
    wire logic [15:0] rd_byte = addr_ff[0] ? rd_odd : rd_even;
    wire logic [15:0] rd_hw = (mem_wd | is_next) ? mem_rdata : rd_byte;
    wire logic [1:0] hw_be = mem_wd ? swdsp_pkg::BE_WORD
        : (addr_ff[0] ? swdsp_pkg::BE_ODD : swdsp_pkg::BE_EVEN);

    // Access routing while executing
    wire logic in_exec = (st_ff == S_EXEC);
    wire logic use_mem = is_mem | (is_next & ~nxt_rej);
    wire logic use_core = fw_any & ~is_next;
    wire logic steal_due = (wait_ff == 8'(swdsp_pkg::STEAL_WAIT - 1));
    wire logic mem_go = in_exec & use_mem & ~issued_ff & ~stop_mode & (bus_free | steal_due)
        & ready_go;
    wire logic bg_done = is_bg & bdm_active;
    wire logic ctl_done = is_ackon | (nxt_rej & ready_go) | bg_done
        | (use_core & issued_ff & core_done)
        | (use_mem & issued_ff & mem_done);
    wire logic [15:0] rd_word = use_mem ? rd_hw : core_rdata;
    wire logic ack_ok = (ack_en_ff | is_ackon) & ~stop_mode;
    wire logic exec_drop = in_exec & stop_mode & ~issued_ff & ready_go;

    // Bit receive and field ends
    wire logic [3:0] fld_last = (st_ff == S_OPC) ? 4'(swdsp_pkg::OPC_BITS - 1)
        : 4'(swdsp_pkg::WORD_BITS - 1);
    wire logic fld_end = ev.bit_done & (bit_ff == fld_last);
    wire logic [15:0] nxt_sh = {sh_ff[14:0], ev.bit_val};
    wire logic busy = ((st_ff == S_OPC) & (bit_ff != 4'h0)) | (st_ff == S_ADDR)
        | (st_ff == S_DATA) | (st_ff == S_TX);
    wire logic gap_ok = (agap_ff == 6'(swdsp_pkg::ACK_GAP));
    wire logic ack_go = (st_ff == S_ACK) & ~ackgo_ff & gap_ok & ack_ok;
    wire logic abort_ev = ev.long_low | (busy & ev.timeout);
    wire logic host_abort = (st_ff == S_ACK) & ~ackgo_ff & ev.fall;

    // Host edges start bits only in the shifting states
    wire logic listen = (st_ff == S_OPC) | (st_ff == S_ADDR) | (st_ff == S_DATA)
        | (st_ff == S_TX);

    swdsp_line_engine u_line (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin_in(debug_wire_pin_in),
        .pin_out(debug_wire_pin_out),
        .pin_oe(debug_wire_pin_oe),
        .listen(listen),
        .tx_mode(st_ff == S_TX),
        .tx_bit(sh_ff[15]),
        .ack_start(ack_go),
        .ev(ev)
    );

    // Bus request: word address always even, byte lane chosen by parity
    assign mem_valid = mem_go;
    assign mem_steal = mem_go & ~bus_free;
    assign mem_cmd.we = ~is_read;
    assign mem_cmd.dbg = is_next ? nxt_dbg : op_ff[swdsp_pkg::OPB_DBG];
    assign mem_cmd.be = is_next ? swdsp_pkg::BE_WORD : hw_be;
    assign mem_cmd.addr = is_next ? {nxt_ptr[15:1], 1'b0} : {addr_ff[15:1], 1'b0};
    assign mem_cmd.wdata = sh_ff;
    assign ptr_bump = mem_go & is_next;

    // Core request
    assign core_valid = in_exec & use_core & ~issued_ff & ~stop_mode & ready_go;
    assign core_cmd.opcode = op_ff;
    assign core_cmd.data = sh_ff;
    assign ack_enabled = ack_en_ff;

    // Request bookkeeping: issue once, count the free-cycle wait
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            issued_ff <= 1'b0;
            wait_ff <= 8'h00;
        end else begin
            issued_ff <= in_exec & (issued_ff | mem_go | core_valid);
            wait_ff <= (in_exec & ~issued_ff & ~mem_go) ? wait_ff + 8'h01 : 8'h00;
        end
    end

    // Gap since the last bit's final tick, saturating
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            agap_ff <= 6'h00;
        end else begin
            agap_ff <= ev.bit_done ? 6'h00 : (gap_ok ? agap_ff : agap_ff + 6'h01);
        end
    end

    // Handshake enable
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ack_en_ff <= 1'b0;
        end else if (in_exec && is_ackon) begin
            ack_en_ff <= 1'b1;
        end else if ((st_ff == S_OPC) && fld_end && (nxt_sh[7:0] == swdsp_pkg::OP_ACK_OFF)) begin
            ack_en_ff <= 1'b0;
        end
    end

    // Completion pulse flags: single pending pulse, started once
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ackgo_ff <= 1'b0;
        end else begin
            ackgo_ff <= (st_ff == S_ACK) & ~abort_ev & (ackgo_ff | ack_go);
        end
    end

    // Shift register and bit counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sh_ff <= 16'h0000;
            bit_ff <= 4'h0;
        end else if (abort_ev || !listen) begin
            bit_ff <= 4'h0;
            if (in_exec && ctl_done && is_read) sh_ff <= rd_word;
        end else if (ev.bit_done) begin
            sh_ff <= nxt_sh;
            bit_ff <= fld_end ? 4'h0 : bit_ff + 4'h1;
        end
    end

    // Opcode and address capture
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            op_ff <= 8'h00;
            addr_ff <= 16'h0000;
        end else begin
            if (st_ff == S_OPC && fld_end) op_ff <= nxt_sh[7:0];
            if (st_ff == S_ADDR && fld_end) addr_ff <= nxt_sh;
        end
    end

    // Command sequencer
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= S_OPC;
        end else if (abort_ev || host_abort) begin
            st_ff <= S_OPC;
        end else begin
            unique case (st_ff)
                S_OPC: if (fld_end) st_ff <= S_EXEC;
                S_ADDR: if (fld_end) st_ff <= mem_rd ? S_EXEC : S_DATA;
                S_DATA: if (fld_end) st_ff <= S_EXEC;
                S_EXEC: begin
                    if (issued_ff || ctl_done || exec_drop) begin
                        if (exec_drop) begin
                            st_ff <= S_OPC;
                        end else if (ctl_done) begin
                            st_ff <= ack_ok ? S_ACK : (is_read ? S_TX : S_OPC);
                        end
                    end else if (is_ackoff || (!is_mem && !is_bg && !is_ackon && !fw_any)) begin
                        st_ff <= S_OPC;
                    end else if (fw_any && !bdm_active) begin
                        st_ff <= S_OPC;
                    end else if (is_mem && !got_addr_ff) begin
                        st_ff <= S_ADDR;
                    end else if (fw_wr && !got_data_ff) begin
                        st_ff <= S_DATA;
                    end
                end
                S_ACK: begin
                    if (!ack_ok && !ackgo_ff) begin
                        st_ff <= S_OPC;
                    end else if (ev.ack_done) begin
                        st_ff <= is_read ? S_TX : S_OPC;
                    end
                end
                S_TX: if (fld_end) st_ff <= S_OPC;
            endcase
        end
    end

    // Fields already shifted in
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            got_addr_ff <= 1'b0;
            got_data_ff <= 1'b0;
        end else if (st_ff == S_OPC) begin
            got_addr_ff <= 1'b0;
            got_data_ff <= 1'b0;
        end else begin
            if (st_ff == S_ADDR && fld_end) got_addr_ff <= 1'b1;
            if (st_ff == S_DATA && fld_end) got_data_ff <= 1'b1;
        end
    end
endmodule : swdsp_top

// ### sim/swdsp_host_pod.sv
/* Debug host pod model: starts every bit, sends, receives, aborts.
   Assumes the bench calls its tasks; wire has a pull-up. */
`timescale 1ns/1ps
module swdsp_host_pod (
    input wire logic clk_sys, // Target clock
    input wire logic dev_oe, // Device drive enable
    input wire logic dev_out, // Device drive value
    output logic pin_level // Resolved wire
);
    logic host_low = 1'b0;
    // Device drive, else host low, else pull-up
    assign pin_level = dev_oe ? dev_out : !host_low;
    // Send n bits, MSB first
    task automatic send(input logic [39:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_sys);
            host_low <= 1'b1;
            repeat (v[i] ? 4 : 13) @(posedge clk_sys);
            host_low <= 1'b0;
            repeat (v[i] ? 16 : 7) @(posedge clk_sys);
        end
    endtask : send
    // Receive a word, MSB first
    task automatic recv(output logic [15:0] v);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_sys);
            host_low <= 1'b1;
            repeat (2) @(posedge clk_sys);
            host_low <= 1'b0;
            repeat (8) @(posedge clk_sys);
            #1 v[i] = pin_level;
            repeat (10) @(posedge clk_sys);
        end
    endtask : recv
    // Cycles until the device pulls low, or -1; stands in for fixed waits
    task automatic wait_ack(input int lim, output int n);
        n = -1;
        for (int i = 0; i < lim && n < 0; i++) begin
            @(posedge clk_sys);
            #1 if (dev_oe && !dev_out) n = i;
        end
        if (n >= 0) repeat (20) @(posedge clk_sys);
    endtask : wait_ack
    // Long low abort
    task automatic long_low(input int len);
        @(posedge clk_sys);
        host_low <= 1'b1;
        repeat (len) @(posedge clk_sys);
        host_low <= 1'b0;
        repeat (20) @(posedge clk_sys);
    endtask : long_low
endmodule : swdsp_host_pod

// ### sim/swdsp_props.sv
/* Concurrent checks on the debug port pins and bus side.
   Bound to swdsp_top; sees its ports only. */
`timescale 1ns/1ps
module swdsp_checker (
    input wire logic clk_sys, // Clock
    input wire logic reset_n, // Reset
    input wire logic debug_wire_pin_out, // Pin value
    input wire logic debug_wire_pin_oe, // Pin enable
    input wire logic bdm_active, // Background active
    input wire logic bus_free, // Free cycle
    input wire logic mem_valid, // Bus request
    input wire logic mem_steal, // Stolen cycle
    input wire swdsp_pkg::swdsp_mem_req_t mem_cmd, // Bus fields
    input wire logic core_valid, // Core request
    input wire logic ptr_bump, // Pointer step
    input wire logic ack_enabled // Handshake on
);
    logic [5:0] low_ff;
    wire logic dev_low = debug_wire_pin_oe && !debug_wire_pin_out;
    wire logic dev_hi = debug_wire_pin_oe && debug_wire_pin_out;
    // Length of the current device-driven low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) low_ff <= 6'h00;
        else low_ff <= dev_low ? low_ff + 6'h01 : 6'h00;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_low_len;
        $fell(dev_low) |-> dev_hi && (low_ff == 6'h0d || low_ff == 6'h10);
    endproperty
    a_low_len: assert property (p_low_len) else $error("low pulse length");
    property p_spd; dev_hi |=> !dev_hi; endproperty
    a_spd: assert property (p_spd) else $error("speedup too long");
    property p_ack_gate; low_ff == 6'h0e |-> ack_enabled; endproperty
    a_ack_gate: assert property (p_ack_gate) else $error("ack while off");
    property p_even; mem_valid |-> !mem_cmd.addr[0]; endproperty
    a_even: assert property (p_even) else $error("odd bus address");
    property p_steal; mem_steal |-> mem_valid && !bus_free; endproperty
    a_steal: assert property (p_steal) else $error("needless steal");
    property p_free; mem_valid && bus_free |-> !mem_steal; endproperty
    a_free: assert property (p_free) else $error("steal on free");
    property p_lanes; mem_valid |-> mem_cmd.be != 2'b00; endproperty
    a_lanes: assert property (p_lanes) else $error("no lanes");
    property p_fw_ro;
        ptr_bump && mem_cmd.we |-> mem_cmd.addr < 16'hff00 || mem_cmd.addr > 16'hff7f;
    endproperty
    a_fw_ro: assert property (p_fw_ro) else $error("firmware write");
    property p_dbg; ptr_bump && mem_cmd.addr >= 16'hff00 |-> mem_cmd.dbg; endproperty
    a_dbg: assert property (p_dbg) else $error("user space hit");
    property p_core; core_valid |-> bdm_active; endproperty
    a_core: assert property (p_core) else $error("core cmd inactive");
    c_steal: cover property (mem_steal);
    c_ack: cover property (low_ff == 6'h10);
    c_bump: cover property (ptr_bump);
endmodule : swdsp_checker
bind swdsp_top swdsp_checker u_swdsp_checker (
    .clk_sys(clk_sys), .reset_n(reset_n), .debug_wire_pin_out(debug_wire_pin_out),
    .debug_wire_pin_oe(debug_wire_pin_oe), .bdm_active(bdm_active), .bus_free(bus_free),
    .mem_valid(mem_valid), .mem_steal(mem_steal), .mem_cmd(mem_cmd),
    .core_valid(core_valid), .ptr_bump(ptr_bump), .ack_enabled(ack_enabled)
);

// ### sim/swdsp_tb_top.sv
/* Self-checking bench of the debug serial port.
   Assumes a one-cycle bus and core answer modelled here. */
`timescale 1ns/1ps
module swdsp_tb_top;
    logic clk_sys, reset_n = 1'b0, stop_mode = 1'b0, bdm_active = 1'b0, bus_free = 1'b1;
    logic mem_done = 1'b0, core_done = 1'b0, pin_level, pin_out, pin_oe, mem_valid;
    logic mem_steal, core_valid, ptr_bump, ack_enabled, last_steal, last_bump;
    logic [15:0] mem_rdata = 16'hc3a5, core_rdata = 16'h0f1e, core_ptr = 16'h0000, v;
    swdsp_pkg::swdsp_mem_req_t mem_cmd, last_cmd;
    swdsp_pkg::swdsp_core_req_t core_cmd;
    int miscompares = 0, cmp_count = 0, mem_cnt = 0, cyc = 0, mem_cyc = 0, n, c0;
    swdsp_top u_swdsp_top (.clk_sys(clk_sys), .reset_n(reset_n),
        .debug_wire_pin_in(pin_level), .debug_wire_pin_out(pin_out),
        .debug_wire_pin_oe(pin_oe), .stop_mode(stop_mode), .bdm_active(bdm_active),
        .bus_free(bus_free), .mem_valid(mem_valid), .mem_steal(mem_steal),
        .mem_cmd(mem_cmd), .mem_done(mem_done), .mem_rdata(mem_rdata),
        .core_valid(core_valid), .core_cmd(core_cmd), .core_done(core_done),
        .core_rdata(core_rdata), .core_ptr(core_ptr), .ptr_bump(ptr_bump),
        .ack_enabled(ack_enabled));
    swdsp_host_pod u_host (.clk_sys(clk_sys), .dev_oe(pin_oe), .dev_out(pin_out),
        .pin_level(pin_level));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // One-cycle bus and core answers; log bus requests
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        mem_done <= mem_valid;
        core_done <= core_valid;
        if (mem_valid === 1'b1) begin
            last_cmd <= mem_cmd;
            last_steal <= mem_steal;
            last_bump <= ptr_bump;
            mem_cnt <= mem_cnt + 1;
            mem_cyc <= cyc;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic t_ack_on();
        u_host.send(40'hd5, 8);
        u_host.wait_ack(600, n);
        check(32'(n >= 30), 32'h1, "ack on gap");
        check({31'h0, ack_enabled}, 32'h1, "ack enabled");
    endtask : t_ack_on
    task automatic t_read(input logic [7:0] op, input logic [15:0] a, input logic [1:0] be,
                          input logic [15:0] exp);
        u_host.send({16'h0, op, a}, 24);
        u_host.wait_ack(600, n);
        check(32'(n >= 0), 32'h1, "read ack");
        check({16'h0, last_cmd.addr}, {16'h0, a & 16'hfffe}, "read addr");
        check({30'h0, last_cmd.be}, {30'h0, be}, "read lanes");
        u_host.recv(v);
        check({16'h0, v}, {16'h0, exp}, "read data");
    endtask : t_read
    task automatic t_write_steal();
        bus_free <= 1'b0;
        u_host.send({8'hc8, 16'h3001, 16'hbeef}, 40);
        c0 = cyc;
        u_host.wait_ack(600, n);
        check(32'(n >= 0), 32'h1, "write ack");
        check({31'h0, last_steal}, 32'h1, "stolen cycle");
        check(32'(mem_cyc - c0 <= 130), 32'h1, "steal wait");
        check({last_cmd.addr, last_cmd.wdata}, 32'h3000beef, "write fields");
        bus_free <= 1'b1;
    endtask : t_write_steal
    task automatic t_fw_next();
        bdm_active <= 1'b1;
        core_ptr <= 16'hff00;
        u_host.send(40'h62, 8);
        u_host.wait_ack(600, n);
        u_host.recv(v);
        check({last_cmd.addr, 15'h0, last_cmd.dbg}, 32'hff020001, "next addr");
        check({15'h0, last_bump, v}, 32'h1c3a5, "next data");
        c0 = mem_cnt;
        core_ptr <= 16'hff0e;
        u_host.send({16'h0, 8'h42, 16'h1234}, 24);
        u_host.wait_ack(600, n);
        check(32'(n >= 0), 32'h1, "protected ack");
        check(32'(mem_cnt - c0), 32'h0, "protected write");
    endtask : t_fw_next
    task automatic t_timeout();
        u_host.send(40'hd, 4);
        repeat (600) @(posedge clk_sys);
        u_host.send(40'hd5, 8);
        u_host.wait_ack(600, n);
        check(32'(n >= 30), 32'h1, "after timeout");
    endtask : t_timeout
    task automatic t_stop();
        stop_mode <= 1'b1;
        u_host.send({16'h0, 8'he8, 16'h4000}, 24);
        u_host.wait_ack(400, n);
        check(32'(n < 0), 32'h1, "stopped ack");
        u_host.long_low(140);
        stop_mode <= 1'b0;
        u_host.send(40'hd5, 8);
        u_host.wait_ack(600, n);
        check(32'(n >= 30), 32'h1, "after abort");
    endtask : t_stop
    task automatic t_ack_off();
        u_host.send(40'hd6, 8);
        u_host.wait_ack(300, n);
        check(32'(n < 0), 32'h1, "ack off pulse");
        check({31'h0, ack_enabled}, 32'h0, "ack disabled");
    endtask : t_ack_off
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        t_ack_on();
        t_read(8'he0, 16'h1235, 2'b01, 16'h00a5);
        t_read(8'he0, 16'h1234, 2'b10, 16'hc300);
        t_read(8'he8, 16'h2001, 2'b11, 16'hc3a5);
        t_write_steal();
        t_fw_next();
        t_timeout();
        t_stop();
        t_ack_off();
        close_out();
    end
endmodule : swdsp_tb_top
